/* rlct_pkg.sv */
/*
  rlct_pkg: constants of the read latency cycle table block.
  Assumes a 250 MHz system clock and a slower host SCK sampled by it.
*/
package rlct_pkg;

  // read command kinds as given by the command decoder
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_FAST = 3'h1;
  localparam logic [2:0] CMD_DOUT = 3'h2;
  localparam logic [2:0] CMD_QOUT = 3'h3;
  localparam logic [2:0] CMD_DIO  = 3'h4;
  localparam logic [2:0] CMD_QIO  = 3'h5;

  // latency codes
  localparam logic [1:0] LC_00 = 2'h0;
  localparam logic [1:0] LC_10 = 2'h2;
  localparam logic [1:0] LC_11 = 2'h3;

  // marker for a command not supported in a band
  localparam logic [7:0] NOT_SUPP = 8'hFF;

  // ddr latency parameter, offsets 00h..2Bh
  localparam int DDR_LEN = 44;
  localparam logic [0:DDR_LEN-1][7:0] DDR_TBL = {
    8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
    8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE,
    8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03,
    8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06,
    8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
    8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08};

  // ddr row bases
  localparam logic [7:0] DDR_ROW_50  = 8'h0C;
  localparam logic [7:0] DDR_ROW_66  = 8'h14;
  localparam logic [7:0] DDR_ROW_LEN = 8'h08;

  // sdr tail rows 5 and 6, offsets 3Ch..57h
  localparam logic [7:0] SDR_BASE = 8'h3C;
  localparam int SDR_LEN = 28;
  localparam logic [0:SDR_LEN-1][7:0] SDR_TBL = {
    8'h68, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h00,
    8'h08, 8'h00, 8'h08, 8'h00, 8'h06, 8'h02, 8'h05,
    8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] SDR_ROW5 = 8'h00;
  localparam logic [7:0] SDR_ROW6 = 8'h0E;

  // reset values
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;

endpackage : rlct_pkg

/* rlct_top.sv */
/*
  rlct_top: mode and dummy cycle selection, cycle counting after the
  address, and the readable latency parameter bytes.
  Assumes cmd, code, band and start come from logic on clk_sys_i;
  sck and chip select arrive from the host pins.
*/
// Summary of operation
// - sdr 104 MHz code 10b: quad-output read 0 mode, 8 dummy
// - sdr 104 MHz: dual-I/O read 0 mode, 6 dummy
// - sdr 104 MHz: quad-I/O read 2 mode, 5 dummy
// - sdr row 6 is 133 MHz (85h), code 10b; fast read 0/8
// - at 133 MHz only fast read; others marked FFh, unsupported
// - ddr parameter starts 9Ah, 2Ah, 05h, 08h
// - header row holds ASCII F and C at 04h and 05h
// - ddr header lists 0Dh/0Eh, BDh/BEh, EDh/EEh, 3-byte form first
// - ddr 50 MHz code 11b: fast, dual-I/O 4 dummy; quad-I/O 3
// - ddr 66 MHz code 00b: dummy 5, 6, 6
// - ddr 66 MHz code 01b: dummy 6, 7, 7
// - ddr 66 MHz code 10b: dummy 7, 8, 8
// - ddr quad-I/O has one mode cycle, others none
// - sdr row 5 is 104 MHz (68h), code 10b
`timescale 1ns/100ps
module rlct_top (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // host pins
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  // read request from the command decoder
  input  wire logic       start_i,
  input  wire logic [2:0] cmd_i,
  input  wire logic       ddr_i,
  input  wire logic [1:0] lat_code_i,
  input  wire logic       band_high_i,
  // query port
  input  wire logic       query_ddr_i,
  input  wire logic [7:0] query_addr_i,
  output logic      [7:0] query_data_o,
  // latency results
  output logic      [7:0] mode_cnt_o,
  output logic      [7:0] dummy_cnt_o,
  output logic            unsupported_o,
  output logic            busy_o,
  output logic            data_phase_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MODE,
    ST_DUMMY,
    ST_DATA
  } rlct_state_t;

  rlct_state_t state_q, state_d;
  logic [2:0] sck_sync_q;
  logic [2:0] cs_sync_q;
  logic       sck_lvl_q;
  logic       cs_n_lvl_q;
  logic [7:0] rem_q, rem_d;

  // sck and chip select: three flops, accepted when the last two agree
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sck_sync_q <= rlct_pkg::SYNC_RST;
      cs_sync_q  <= rlct_pkg::SYNC_RST;
      sck_lvl_q  <= 1'b1;
      cs_n_lvl_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      cs_sync_q  <= {cs_sync_q[1:0], cs_n_i};
      if (sck_sync_q[1] == sck_sync_q[2]) begin
        sck_lvl_q <= sck_sync_q[2];
      end
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_n_lvl_q <= cs_sync_q[2];
      end
    end
  end

  wire sck_ok   = sck_sync_q[1] == sck_sync_q[2];
  wire sck_rise = sck_ok & sck_sync_q[2] & ~sck_lvl_q;
  wire cs_ok    = cs_sync_q[1] == cs_sync_q[2];
  wire cs_end   = cs_ok & cs_sync_q[2] & ~cs_n_lvl_q;
  wire frame_on = ~cs_n_lvl_q;

  wire [7:0] ddr_row = (lat_code_i == rlct_pkg::LC_11) ? rlct_pkg::DDR_ROW_50
                     : rlct_pkg::DDR_ROW_66 + rlct_pkg::DDR_ROW_LEN * {6'h00, lat_code_i};
  wire [1:0] ddr_slot = (cmd_i == rlct_pkg::CMD_FAST) ? 2'h0
                      : (cmd_i == rlct_pkg::CMD_DIO)  ? 2'h1 : 2'h2;
  wire ddr_cmd_ok = (cmd_i == rlct_pkg::CMD_FAST) | (cmd_i == rlct_pkg::CMD_DIO)
                  | (cmd_i == rlct_pkg::CMD_QIO);
  // mode and dummy pair per command
  wire [7:0] ddr_idx = ddr_row + 8'h02 + {5'h00, ddr_slot, 1'b0};
  wire [7:0] ddr_mode  = rlct_pkg::DDR_TBL[ddr_idx[5:0]];
  wire [7:0] ddr_dummy = rlct_pkg::DDR_TBL[ddr_idx[5:0] + 6'h01];

  // sdr row pick by band; only code 10b rows are held
  wire [7:0] sdr_row  = band_high_i ? rlct_pkg::SDR_ROW6 : rlct_pkg::SDR_ROW5;
  wire [7:0] sdr_idx  = sdr_row + 8'h02 + {4'h0, cmd_i, 1'b0};
  wire [7:0] sdr_mode  = rlct_pkg::SDR_TBL[sdr_idx[4:0]];
  wire [7:0] sdr_dummy = rlct_pkg::SDR_TBL[sdr_idx[4:0] + 5'h01];
  wire sdr_cmd_ok = (cmd_i <= rlct_pkg::CMD_QIO) & (lat_code_i == rlct_pkg::LC_10);

  wire [7:0] sel_mode  = ddr_i ? ddr_mode : sdr_mode;
  wire [7:0] sel_dummy = ddr_i ? ddr_dummy : sdr_dummy;
  wire sel_bad = (ddr_i ? ~ddr_cmd_ok : ~sdr_cmd_ok)
               | (sel_mode == rlct_pkg::NOT_SUPP) | (sel_dummy == rlct_pkg::NOT_SUPP);
  wire go = start_i & frame_on & (state_q == ST_IDLE);

  // mode count, then dummy count, then data
  always_comb begin
    state_d = state_q;
    rem_d   = rem_q;
    case (state_q)
      ST_IDLE: begin
        if (go && !sel_bad) begin
          if (sel_mode != rlct_pkg::CNT_RST) begin
            state_d = ST_MODE;
            rem_d   = sel_mode;
          end else if (sel_dummy != rlct_pkg::CNT_RST) begin
            state_d = ST_DUMMY;
            rem_d   = sel_dummy;
          end else begin
            state_d = ST_DATA;
          end
        end
      end
      ST_MODE: begin
        if (sck_rise) begin
          rem_d = rem_q - 8'h01;
          if (rem_q == 8'h01) begin
            state_d = (dummy_cnt_o == rlct_pkg::CNT_RST) ? ST_DATA : ST_DUMMY;
            rem_d   = dummy_cnt_o;
          end
        end
      end
      ST_DUMMY: begin
        if (sck_rise) begin
          rem_d = rem_q - 8'h01;
          if (rem_q == 8'h01) begin
            state_d = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        state_d = ST_DATA;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // end of frame aborts any read
    if (cs_end) begin
      state_d = ST_IDLE;
      rem_d   = rlct_pkg::CNT_RST;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      rem_q   <= rlct_pkg::CNT_RST;
    end else begin
      state_q <= state_d;
      rem_q   <= rem_d;
    end
  end

  // latched selection; a refused request leaves counts at zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_cnt_o    <= rlct_pkg::CNT_RST;
      dummy_cnt_o   <= rlct_pkg::CNT_RST;
      unsupported_o <= 1'b0;
    end else if (go) begin
      mode_cnt_o    <= sel_bad ? rlct_pkg::CNT_RST : sel_mode;
      dummy_cnt_o   <= sel_bad ? rlct_pkg::CNT_RST : sel_dummy;
      unsupported_o <= sel_bad;
    end else if (cs_end) begin
      unsupported_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_o       <= 1'b0;
      data_phase_o <= 1'b0;
    end else begin
      busy_o       <= (state_d == ST_MODE) | (state_d == ST_DUMMY);
      data_phase_o <= state_d == ST_DATA;
    end
  end

  // parameter bytes; offsets outside the held rows read 00h
  wire q_ddr_hit = query_addr_i < 8'(rlct_pkg::DDR_LEN);
  wire [7:0] q_sdr_off = query_addr_i - rlct_pkg::SDR_BASE;
  wire q_sdr_hit = (query_addr_i >= rlct_pkg::SDR_BASE) & (q_sdr_off < 8'(rlct_pkg::SDR_LEN));
  wire [7:0] q_byte = query_ddr_i ? (q_ddr_hit ? rlct_pkg::DDR_TBL[query_addr_i[5:0]] : 8'h00)
                    : (q_sdr_hit ? rlct_pkg::SDR_TBL[q_sdr_off[4:0]] : 8'h00);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      query_data_o <= rlct_pkg::CNT_RST;
    end else begin
      query_data_o <= q_byte;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  wire sdr104 = go & ~ddr_i & ~band_high_i & (lat_code_i == rlct_pkg::LC_10);
  wire sdr133 = go & ~ddr_i & band_high_i & (lat_code_i == rlct_pkg::LC_10);
  wire ddr_go = go & ddr_i;

  sdr_qout_a: assert property (
    sdr104 && cmd_i == rlct_pkg::CMD_QOUT |=> mode_cnt_o == 8'h00 && dummy_cnt_o == 8'h08)
    else $error("sdr quad out counts wrong");
  sdr_dio_a: assert property (
    sdr104 && cmd_i == rlct_pkg::CMD_DIO |=> mode_cnt_o == 8'h00 && dummy_cnt_o == 8'h06)
    else $error("sdr dual io counts wrong");
  sdr_qio_a: assert property (
    sdr104 && cmd_i == rlct_pkg::CMD_QIO |=> mode_cnt_o == 8'h02 && dummy_cnt_o == 8'h05)
    else $error("sdr quad io counts wrong");
  sdr_fast_a: assert property (
    sdr133 && cmd_i == rlct_pkg::CMD_FAST |=> !unsupported_o && dummy_cnt_o == 8'h08)
    else $error("sdr 133 fast read counts wrong");
  sdr_refuse_a: assert property (
    sdr133 && cmd_i != rlct_pkg::CMD_FAST |=> unsupported_o && !busy_o && !data_phase_o)
    else $error("unsupported read accepted at 133");
  row5_code_a: assert property (
    sdr104 && cmd_i == rlct_pkg::CMD_FAST |=> !unsupported_o)
    else $error("row 5 fast read refused");
  ddr_head_a: assert property (
    query_ddr_i && query_addr_i == 8'h01 |=> query_data_o == 8'h2A)
    else $error("ddr length byte wrong");
  hdr_ascii_a: assert property (
    query_ddr_i && query_addr_i == 8'h04 |=> query_data_o == 8'h46)
    else $error("header F byte wrong");
  ddr_opc_a: assert property (
    query_ddr_i && query_addr_i == 8'h0A |=> query_data_o == 8'hED)
    else $error("ddr quad io opcode wrong");
  ddr50_qio_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_11 && cmd_i == rlct_pkg::CMD_QIO
    |=> dummy_cnt_o == 8'h03)
    else $error("ddr 50 quad io dummy wrong");
  ddr00_dio_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_00 && cmd_i == rlct_pkg::CMD_DIO
    |=> dummy_cnt_o == 8'h06)
    else $error("ddr code 00 dual io dummy wrong");
  ddr01_fast_a: assert property (
    ddr_go && lat_code_i == 2'h1 && cmd_i == rlct_pkg::CMD_FAST |=> dummy_cnt_o == 8'h06)
    else $error("ddr code 01 fast dummy wrong");
  ddr10_qio_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_10 && cmd_i == rlct_pkg::CMD_QIO
    |=> dummy_cnt_o == 8'h08)
    else $error("ddr code 10 quad io dummy wrong");
  ddr_mode_a: assert property (
    ddr_go && cmd_i == rlct_pkg::CMD_QIO |=> mode_cnt_o == 8'h01)
    else $error("ddr quad io mode count wrong");

  sequence last_dummy_s;
    state_q == ST_DUMMY && rem_q == 8'h01 && sck_rise && !cs_end;
  endsequence
  sequence data_now_s;
    ##1 data_phase_o && !busy_o;
  endsequence
  count_done_a: assert property (
    last_dummy_s |-> data_now_s)
    else $error("data not started after dummy count");
  count_hold_a: assert property (
    state_q == ST_DUMMY && !sck_rise && !cs_end |=> rem_q == $past(rem_q) && !data_phase_o)
    else $error("dummy count moved without sck edge");

  // the dummy count must be loaded whole when the last mode cycle passes
  sequence last_mode_s;
    state_q == ST_MODE && rem_q == 8'h01 && sck_rise && !cs_end && dummy_cnt_o != 8'h00;
  endsequence
  sequence dummy_load_s;
    ##1 busy_o && !data_phase_o && rem_q == dummy_cnt_o;
  endsequence
  mode_to_dummy_a: assert property (
    last_mode_s |-> dummy_load_s)
    else $error("dummy count not loaded after mode cycles");
  ddr50_fast_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_11 && cmd_i == rlct_pkg::CMD_FAST
    |=> mode_cnt_o == 8'h00 && dummy_cnt_o == 8'h04)
    else $error("ddr 50 fast dummy wrong");
  ddr00_qio_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_00 && cmd_i == rlct_pkg::CMD_QIO
    |=> dummy_cnt_o == 8'h06)
    else $error("ddr code 00 quad io dummy wrong");
  ddr01_dio_a: assert property (
    ddr_go && lat_code_i == 2'h1 && cmd_i == rlct_pkg::CMD_DIO |=> dummy_cnt_o == 8'h07)
    else $error("ddr code 01 dual io dummy wrong");
  ddr10_fast_a: assert property (
    ddr_go && lat_code_i == rlct_pkg::LC_10 && cmd_i == rlct_pkg::CMD_FAST
    |=> dummy_cnt_o == 8'h07)
    else $error("ddr code 10 fast dummy wrong");
  ddr_nomode_a: assert property (
    ddr_go && (cmd_i == rlct_pkg::CMD_FAST || cmd_i == rlct_pkg::CMD_DIO)
    |=> mode_cnt_o == 8'h00 && !unsupported_o)
    else $error("ddr fast or dual io mode count wrong");
  hdr_code_a: assert property (
    query_ddr_i && query_addr_i == 8'h05 |=> query_data_o == 8'h43)
    else $error("header C byte wrong");
  ddr_rows_a: assert property (
    query_ddr_i && query_addr_i == 8'h02 |=> query_data_o == 8'h05)
    else $error("ddr row count byte wrong");
  sdr_row6_a: assert property (
    !query_ddr_i && query_addr_i == 8'h4A |=> query_data_o == 8'h85)
    else $error("sdr row 6 frequency byte wrong");

endmodule : rlct_top

/* rlct_host_model.sv */
/*
  rlct_host_model: host controller side of the flash link, drives SCK and
  chip select. Assumes the bench tells it how many clocks a read needs.
*/
`timescale 1ns/100ps
module rlct_host_model (
  // host pins toward the flash
  output logic sck_o,
  output logic cs_n_o
);
  // sck idles low, no clock outside a frame
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
  end

  task open_frame;
    cs_n_o = 1'b0;
  endtask : open_frame

  task automatic pulses(input int n, input int half);
    repeat (n) begin
      #(half) sck_o = 1'b1;
      #(half) sck_o = 1'b0;
    end
  endtask : pulses

  task close_frame;
    #16 cs_n_o = 1'b1;
  endtask : close_frame
endmodule : rlct_host_model

/* tb.sv */
/*
  tb: self-checking bench for rlct_top with a host model on the link.
  Assumes the package constants and the hand-over timing of rlct_top.
*/
`timescale 1ns/100ps
module tb;
  logic       clk_sys_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, ddr_i = 1'b0;
  logic       band_high_i = 1'b0, query_ddr_i = 1'b0;
  logic [2:0] cmd_i = 3'h0;
  logic [1:0] lat_code_i = 2'h0;
  logic [7:0] query_addr_i = 8'h00, query_data_o, mode_cnt_o, dummy_cnt_o;
  logic       sck_i, cs_n_i, unsupported_o, busy_o, data_phase_o;
  integer     seed = 32'h1F85;
  int         err_total = 0, comparisons = 0, cyc = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  rlct_host_model rlct_host_model_inst (.sck_o(sck_i), .cs_n_o(cs_n_i));
  rlct_top rlct_top_inst (.clk_sys_i, .reset_i, .sck_i, .cs_n_i, .start_i, .cmd_i, .ddr_i,
    .lat_code_i, .band_high_i, .query_ddr_i, .query_addr_i, .query_data_o, .mode_cnt_o,
    .dummy_cnt_o, .unsupported_o, .busy_o, .data_phase_o);

  // expected {mode, dummy}; FFFFh when refused
  function automatic logic [15:0] m(input logic d, h, input logic [1:0] c, input logic [2:0] k);
    int b;
    b = 5 + c;
    if (d) begin
      if (k != 1 && k != 4 && k != 5) return 16'hFFFF;
      if (c == 3) return (k == 5) ? 16'h0103 : 16'h0004;
      return (k == 5) ? {8'h01, 8'(b + 1)} : (k == 4) ? {8'h00, 8'(b + 1)} : {8'h00, 8'(b)};
    end
    if (c != 2 || k == 0) return 16'hFFFF;
    if (h) return (k == 1) ? 16'h0008 : 16'hFFFF;
    return (k == 5) ? 16'h0205 : (k == 4) ? 16'h0006 : 16'h0008;
  endfunction : m

  function automatic logic [7:0] qx(input logic d, input int a);
    logic [7:0] hdr [12] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
                             8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
    int r, i;
    logic [7:0] f;
    logic [1:0] c;
    logic [2:0] k;
    logic [15:0] v;
    if (d && a < 12) return hdr[a];
    if (d && a >= 12 && a < 44) begin
      r = (a - 12) / 8;
      i = (a - 12) % 8;
      f = (r != 0) ? 8'h42 : 8'h32;
      c = (r != 0) ? 2'(r - 1) : 2'h3;
      k = (i < 4) ? 3'h1 : (i < 6) ? 3'h4 : 3'h5;
    end else if (!d && a >= 60 && a < 88) begin
      r = (a - 60) / 14;
      i = (a - 60) % 14;
      f = (r != 0) ? 8'h85 : 8'h68;
      c = 2'h2;
      k = 3'((i - 2) / 2);
    end else return 8'h00;
    v = m(d, r[0], c, k);
    return (i == 0) ? f : (i == 1) ? {6'h00, c} : i[0] ? v[7:0] : v[15:8];
  endfunction : qx

  task automatic chk8(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk1

  task automatic q(input logic d, input logic [7:0] a);
    query_ddr_i = d;
    query_addr_i = a;
    @(negedge clk_sys_i);
    chk8(query_data_o, qx(d, a));
  endtask : q

  task automatic rd(input logic d, h, input logic [1:0] c, input logic [2:0] k);
    logic [15:0] e;
    int n, hp;
    e = m(d, h, c, k);
    // half of the 32 ns sck period
    hp = 16;
    rlct_host_model_inst.open_frame();
    repeat (5) @(negedge clk_sys_i);
    {ddr_i, band_high_i, lat_code_i, cmd_i, start_i} = {d, h, c, k, 1'b1};
    @(negedge clk_sys_i);
    start_i = 1'b0;
    @(negedge clk_sys_i);
    chk1(unsupported_o, e == 16'hFFFF);
    chk8(mode_cnt_o, (e == 16'hFFFF) ? 8'h00 : e[15:8]);
    chk8(dummy_cnt_o, (e == 16'hFFFF) ? 8'h00 : e[7:0]);
    if (e != 16'hFFFF) begin
      n = e[15:8] + e[7:0];
      chk1(busy_o, 1'b1);
      rlct_host_model_inst.pulses(n - 1, hp);
      repeat (8) @(negedge clk_sys_i);
      chk1(data_phase_o, 1'b0);
      rlct_host_model_inst.pulses(1, hp);
      repeat (8) @(negedge clk_sys_i);
      chk1(data_phase_o, 1'b1);
      chk1(busy_o, 1'b0);
    end
    rlct_host_model_inst.close_frame();
    repeat (6) @(negedge clk_sys_i);
    chk1(data_phase_o, 1'b0);
    chk1(unsupported_o, 1'b0);
  endtask : rd

  task print_verdict;
    $display("counts: comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // ceiling well above the roughly 3800 cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i) reset_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    for (int a = 0; a < 46; a++) q(1'b1, 8'(a));
    q(1'b1, 8'h01);
    chk8(query_data_o + 8'h02, 8'h2C);
    for (int a = 58; a < 90; a++) q(1'b0, 8'(a));
    repeat (32) q(1'($random(seed)), 8'($random(seed)));
    $display("test query done");
    for (int d = 0; d < 2; d++)
      for (int h = 0; h < 2; h++)
        for (int c = 0; c < 4; c++)
          for (int k = 0; k < 6; k++) rd(1'(d), 1'(h), 2'(c), 3'(k));
    $display("test reads done");
    print_verdict();
  end
endmodule : tb
